// [rtl/nvmps_pkg.sv]
// nvmps_pkg: constants for the non-volatile program/verify/security block
package nvmps_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int PROG_PULSE_US = 100;
    localparam int PROG_PULSE_CYCLES = PROG_PULSE_US * CLK_MHZ;
    localparam int ENTRY_HIGH_CYCLES = 2;

    // ------------------------------------------------------------
    // port zero operation codes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_PROG_CODE = 8'h68;
    localparam logic [7:0] OP_PROG_CFG = 8'h69;
    localparam logic [7:0] OP_PROG_LOCK = 8'h6b;
    localparam logic [7:0] OP_PROG_KEY = 8'h6c;
    localparam logic [7:0] OP_VFY_CODE = 8'h28;
    localparam logic [7:0] OP_VFY_CFG = 8'h29;
    localparam logic [7:0] OP_VFY_LOCK = 8'h2b;
    localparam logic [7:0] OP_IDLE = 8'hff;

    // ------------------------------------------------------------
    // fixed addresses
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_CFG_FIRST = 16'hfff8;
    localparam logic [15:0] ADDR_CFG_SECOND = 16'hfff9;
    localparam logic [15:0] ADDR_LOCK_ZERO = 16'h0001;
    localparam logic [15:0] ADDR_LOCK_ONE = 16'h0002;
    localparam logic [15:0] ADDR_LOCK_TWO = 16'h0003;
    localparam logic [15:0] ADDR_SIG_VENDOR = 16'h0030;
    localparam logic [15:0] ADDR_SIG_ARCH = 16'h0031;
    localparam logic [15:0] ADDR_SIG_MEMORY = 16'h0060;
    localparam logic [15:0] ADDR_SIG_REV = 16'h0061;
    localparam int KEY_AW = 7;

    // ------------------------------------------------------------
    // values
    // ------------------------------------------------------------
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [2:0] LOCK_RESET = 3'h0;
    localparam logic [1:0] LEVEL_0 = 2'h0;
    localparam logic [1:0] LEVEL_1 = 2'h1;
    localparam logic [1:0] LEVEL_2 = 2'h2;
    localparam logic [1:0] LEVEL_3 = 2'h3;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_TABLE_ADDR = 4'h4;
    localparam logic [3:0] REG_TABLE_DATA = 4'h8;
    localparam int ST_LOCK_LSB = 0;
    localparam int ST_LEVEL_LSB = 3;
    localparam int ST_SESSION_BIT = 5;

    typedef enum {NVMPS_EPROM, NVMPS_MASK, NVMPS_ROMLESS} nvmps_variant_e;
endpackage : nvmps_pkg

// [rtl/nvmps_byte_mem.sv]
// nvmps_byte_mem: byte array with clear-only writes and two registered read ports
`timescale 1ns/1ps
module nvmps_byte_mem #(
    parameter int AW = 7
) (
    input wire logic core_clk_in,
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic [AW-1:0] rd_a_addr_in,
    output logic [7:0] rd_a_data_out,
    input wire logic [AW-1:0] rd_b_addr_in,
    output logic [7:0] rd_b_data_out
);
    localparam int DEPTH = 1 << AW;
    logic [7:0] mem [DEPTH];

    if (AW < 1 || AW > 16) begin : g_bad_aw
        $error("nvmps_byte_mem: AW out of range");
    end

    // cells start erased; no reset so the array maps to block memory
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            mem[i] = nvmps_pkg::ERASED_BYTE;
        end
    end

    // programming can only pull bits to zero
    always_ff @(posedge core_clk_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= mem[wr_addr_in] & wr_data_in;
        end
    end

    always_ff @(posedge core_clk_in) begin
        rd_a_data_out <= mem[rd_a_addr_in];
        rd_b_data_out <= mem[rd_b_addr_in];
    end
endmodule : nvmps_byte_mem

// [rtl/nvmps_core.sv]
// nvmps_core: parallel program/verify access, lock levels and verify encryption
//
// The address map and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
module nvmps_core #(
    parameter nvmps_pkg::nvmps_variant_e VARIANT = nvmps_pkg::NVMPS_EPROM,
    parameter int CODE_AW = 15,
    parameter int PROG_PULSE_CYCLES = nvmps_pkg::PROG_PULSE_CYCLES,
    parameter logic MASK_LOCK_BIT = 1'b0,
    parameter logic [7:0] SIG_VENDOR = 8'h11,   // arbitrary value
    parameter logic [7:0] SIG_ARCH = 8'h22,     // arbitrary value
    parameter logic [7:0] SIG_MEMORY = 8'h33,   // arbitrary value
    parameter logic [7:0] SIG_REV = 8'h44       // arbitrary value
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic chip_reset_pin_in,
    input wire logic code_fetch_strobe_n_in,
    input wire logic latch_program_pulse_n_in,
    input wire logic external_access_hv_pin_in,
    input wire logic [7:0] port_zero_in,
    input wire logic [7:0] port_one_in,
    input wire logic [7:0] port_two_in,
    input wire logic [7:0] port_three_in,
    output logic [7:0] port_two_out,
    output logic port_two_oe_n_out,
    output logic ext_exec_enable_out,
    output logic int_exec_enable_out,
    output logic session_active_out,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out
);
    if (CODE_AW < 8 || CODE_AW > 15 || PROG_PULSE_CYCLES < 1 || PROG_PULSE_CYCLES > 65535) begin : g_bad_param
        $error("nvmps_core: parameter out of range");
    end

    localparam logic [15:0] PULSE_LAST = 16'(PROG_PULSE_CYCLES - 1);
    localparam logic [15:0] PULSE_TOP = 16'(PROG_PULSE_CYCLES);
    localparam logic [1:0] ENTRY_MIN = 2'(nvmps_pkg::ENTRY_HIGH_CYCLES);
    localparam logic HAS_CODE = (VARIANT != nvmps_pkg::NVMPS_ROMLESS);
    localparam logic CAN_PROG = (VARIANT == nvmps_pkg::NVMPS_EPROM);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // highest set bit wins
    function automatic logic [1:0] level_of(input logic [2:0] bits);
        if (bits[2]) begin
            return nvmps_pkg::LEVEL_3;
        end else if (bits[1]) begin
            return nvmps_pkg::LEVEL_2;
        end else if (bits[0]) begin
            return nvmps_pkg::LEVEL_1;
        end
        return nvmps_pkg::LEVEL_0;
    endfunction : level_of

    function automatic logic in_code(input logic [15:0] a);
        return HAS_CODE && ((a >> CODE_AW) == 16'h0000);
    endfunction : in_code

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [35:0] pin_meta;
    logic [35:0] pin_sync;

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {chip_reset_pin_in, code_fetch_strobe_n_in, latch_program_pulse_n_in,
                         external_access_hv_pin_in, port_zero_in, port_one_in, port_two_in, port_three_in};
            pin_sync <= pin_meta;
        end
    end

    logic rst_pin;
    logic strobe_n;
    logic latch_n;
    logic hv;
    logic [7:0] op;
    logic [15:0] addr;
    logic [7:0] wdata;

    assign rst_pin = pin_sync[35];
    assign strobe_n = pin_sync[34];
    assign latch_n = pin_sync[33];
    assign hv = pin_sync[32];
    assign op = pin_sync[31:24];
    assign addr = {pin_sync[23:16], pin_sync[7:0]};
    assign wdata = pin_sync[15:8];

    // ------------------------------------------------------------
    // session entry and exit
    // ------------------------------------------------------------
    typedef enum {NVMPS_IDLE, NVMPS_ARMED, NVMPS_SESSION} nvmps_state_e;
    nvmps_state_e state;
    logic [1:0] high_cnt;

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= NVMPS_IDLE;
            high_cnt <= '0;
        end else begin
            case (state)
                NVMPS_IDLE: begin
                    high_cnt <= '0;
                    if (rst_pin && strobe_n && latch_n && op == nvmps_pkg::OP_IDLE) begin
                        state <= NVMPS_ARMED;
                    end
                end
                NVMPS_ARMED: begin
                    if (high_cnt != ENTRY_MIN) begin
                        high_cnt <= high_cnt + 2'h1;
                    end
                    if (!rst_pin) begin
                        state <= NVMPS_IDLE;
                    end else if (!strobe_n) begin
                        state <= (high_cnt == ENTRY_MIN) ? NVMPS_SESSION : NVMPS_IDLE;
                    end
                end
                NVMPS_SESSION: begin
                    if (!rst_pin || strobe_n) begin
                        state <= NVMPS_IDLE;
                    end
                end
                default: begin
                    state <= NVMPS_IDLE;
                end
            endcase
        end
    end

    logic in_session;
    assign in_session = (state == NVMPS_SESSION);

    // ------------------------------------------------------------
    // program pulse timing
    // ------------------------------------------------------------
    // the counter saturates, so a long pulse still writes only once
    logic [15:0] pulse_cnt;
    logic fire;

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pulse_cnt <= '0;
        end else if (!in_session || !hv || latch_n) begin
            pulse_cnt <= '0;
        end else if (pulse_cnt != PULSE_TOP) begin
            pulse_cnt <= pulse_cnt + 16'h0001;
        end
    end

    assign fire = in_session && hv && !latch_n && pulse_cnt == PULSE_LAST;

    // ------------------------------------------------------------
    // lock bits and configuration bytes
    // ------------------------------------------------------------
    logic [2:0] lock_cells;
    logic [2:0] lock_level_bits;
    logic [1:0] level;
    logic [7:0] config_byte_first;
    logic [7:0] config_byte_second;
    logic prog_open;

    // mask parts carry a factory level-one bit only
    assign lock_level_bits = (VARIANT == nvmps_pkg::NVMPS_MASK) ? {2'b00, MASK_LOCK_BIT} : lock_cells;
    assign level = level_of(lock_level_bits);
    // level one and above close code, config and key programming
    assign prog_open = CAN_PROG && fire && level == nvmps_pkg::LEVEL_0;

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lock_cells <= nvmps_pkg::LOCK_RESET;
        end else if (CAN_PROG && fire && op == nvmps_pkg::OP_PROG_LOCK) begin
            // port two is ignored for lock writes
            case (addr)
                nvmps_pkg::ADDR_LOCK_ZERO: lock_cells[0] <= 1'b1;
                nvmps_pkg::ADDR_LOCK_ONE: lock_cells[1] <= 1'b1;
                nvmps_pkg::ADDR_LOCK_TWO: lock_cells[2] <= 1'b1;
                default: lock_cells <= lock_cells;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            config_byte_first <= nvmps_pkg::ERASED_BYTE;
            config_byte_second <= nvmps_pkg::ERASED_BYTE;
        end else if (prog_open && HAS_CODE && op == nvmps_pkg::OP_PROG_CFG) begin
            if (addr == nvmps_pkg::ADDR_CFG_FIRST) begin
                config_byte_first <= config_byte_first & wdata;
            end
            if (addr == nvmps_pkg::ADDR_CFG_SECOND) begin
                config_byte_second <= config_byte_second & wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // code memory and key array
    // ------------------------------------------------------------
    logic code_wr;
    logic key_wr;
    logic [7:0] code_vfy;
    logic [7:0] code_tbl;
    logic [7:0] key_byte;
    logic [CODE_AW-1:0] table_addr;

    assign code_wr = prog_open && op == nvmps_pkg::OP_PROG_CODE && in_code(addr);
    assign key_wr = prog_open && HAS_CODE && op == nvmps_pkg::OP_PROG_KEY && addr[15:nvmps_pkg::KEY_AW] == '0;

    nvmps_byte_mem #(.AW(CODE_AW)) u_code (
        .core_clk_in(core_clk_in),
        .wr_en_in(code_wr),
        .wr_addr_in(addr[CODE_AW-1:0]),
        .wr_data_in(wdata),
        .rd_a_addr_in(addr[CODE_AW-1:0]),
        .rd_a_data_out(code_vfy),
        .rd_b_addr_in(table_addr),
        .rd_b_data_out(code_tbl)
    );

    // key is only read into the XNOR path, never to a port
    nvmps_byte_mem #(.AW(nvmps_pkg::KEY_AW)) u_key (
        .core_clk_in(core_clk_in),
        .wr_en_in(key_wr),
        .wr_addr_in(addr[nvmps_pkg::KEY_AW-1:0]),
        .wr_data_in(wdata),
        .rd_a_addr_in(addr[nvmps_pkg::KEY_AW-1:0]),
        .rd_a_data_out(key_byte),
        .rd_b_addr_in(addr[nvmps_pkg::KEY_AW-1:0]),
        .rd_b_data_out()
    );

    // ------------------------------------------------------------
    // verify path
    // ------------------------------------------------------------
    logic [7:0] next_port_two;
    logic vfy_op;

    assign vfy_op = op == nvmps_pkg::OP_VFY_CODE || op == nvmps_pkg::OP_VFY_CFG || op == nvmps_pkg::OP_VFY_LOCK;

    always_comb begin
        next_port_two = nvmps_pkg::ERASED_BYTE;
        case (op)
            nvmps_pkg::OP_VFY_CODE: begin
                if (in_code(addr) && level < nvmps_pkg::LEVEL_2) begin
                    next_port_two = code_vfy ~^ key_byte;
                end
            end
            nvmps_pkg::OP_VFY_CFG: begin
                case (addr)
                    nvmps_pkg::ADDR_CFG_FIRST: next_port_two = HAS_CODE ? config_byte_first : nvmps_pkg::ERASED_BYTE;
                    nvmps_pkg::ADDR_CFG_SECOND: next_port_two = HAS_CODE ? config_byte_second : nvmps_pkg::ERASED_BYTE;
                    nvmps_pkg::ADDR_SIG_VENDOR: next_port_two = SIG_VENDOR;
                    nvmps_pkg::ADDR_SIG_ARCH: next_port_two = SIG_ARCH;
                    nvmps_pkg::ADDR_SIG_MEMORY: next_port_two = SIG_MEMORY;
                    nvmps_pkg::ADDR_SIG_REV: next_port_two = SIG_REV;
                    default: next_port_two = nvmps_pkg::ERASED_BYTE;
                endcase
            end
            nvmps_pkg::OP_VFY_LOCK: next_port_two = {5'b00000, lock_level_bits};
            default: next_port_two = nvmps_pkg::ERASED_BYTE;
        endcase
    end

    // port two is only driven while high voltage is off
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            port_two_out <= nvmps_pkg::ERASED_BYTE;
            port_two_oe_n_out <= 1'b1;
        end else begin
            port_two_out <= next_port_two;
            port_two_oe_n_out <= !(in_session && !hv && vfy_op);
        end
    end

    // ------------------------------------------------------------
    // execution gates
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ext_exec_enable_out <= 1'b1;
            int_exec_enable_out <= 1'b0;
            session_active_out <= 1'b0;
        end else begin
            ext_exec_enable_out <= level != nvmps_pkg::LEVEL_3;
            int_exec_enable_out <= 1'b1;
            session_active_out <= in_session;
        end
    end

    // ------------------------------------------------------------
    // avalon slave: status, table address, table data
    // ------------------------------------------------------------
    // every access waits two cycles so table data has left the memory register
    logic [1:0] bus_step;
    logic bus_req;
    logic [31:0] next_readdata;

    assign bus_req = avs_read_in || avs_write_in;

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bus_step <= 2'h0;
            avs_waitrequest_out <= 1'b1;
        end else if (bus_step == 2'h0 && bus_req) begin
            bus_step <= 2'h1;
        end else if (bus_step == 2'h1) begin
            bus_step <= 2'h2;
            avs_waitrequest_out <= 1'b0;
        end else if (bus_step == 2'h2) begin
            bus_step <= 2'h0;
            avs_waitrequest_out <= 1'b1;
        end
    end

    localparam int ST_LOCK_LSB = nvmps_pkg::ST_LOCK_LSB;
    localparam int ST_LEVEL_LSB = nvmps_pkg::ST_LEVEL_LSB;
    localparam int ST_SESSION_BIT = nvmps_pkg::ST_SESSION_BIT;

    always_comb begin
        next_readdata = 32'h0000_0000;
        case (avs_address_in)
            nvmps_pkg::REG_STATUS: begin
                next_readdata[ST_LOCK_LSB +: 3] = lock_level_bits;
                next_readdata[ST_LEVEL_LSB +: 2] = level;
                next_readdata[ST_SESSION_BIT] = in_session;
            end
            nvmps_pkg::REG_TABLE_ADDR: next_readdata[CODE_AW-1:0] = table_addr;
            nvmps_pkg::REG_TABLE_DATA: begin
                // plain bytes, closed from level one upward
                if (HAS_CODE && level == nvmps_pkg::LEVEL_0) begin
                    next_readdata[7:0] = code_tbl;
                end
            end
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            avs_readdata_out <= 32'h0000_0000;
            table_addr <= '0;
        end else begin
            if (bus_step == 2'h1) begin
                avs_readdata_out <= avs_read_in ? next_readdata : 32'h0000_0000;
            end
            if (bus_step == 2'h2 && avs_write_in && avs_address_in == nvmps_pkg::REG_TABLE_ADDR) begin
                table_addr <= avs_writedata_in[CODE_AW-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);

    a_refused_prog: assert property (code_wr || key_wr |-> level == nvmps_pkg::LEVEL_0)
        else $error("code or key written while locked");
    a_single_write: assert property (fire |=> !fire [*8])
        else $error("second write in one pulse");
    a_code_block: assert property (in_session && op == nvmps_pkg::OP_VFY_CODE && level >= nvmps_pkg::LEVEL_2
        |=> port_two_out == nvmps_pkg::ERASED_BYTE)
        else $error("code verify not blocked");
    a_lock_readback: assert property (op == nvmps_pkg::OP_VFY_LOCK |=> port_two_out == {5'b00000, $past(lock_level_bits)})
        else $error("lock verify byte wrong");
    a_ext_exec: assert property (##1 ext_exec_enable_out == ($past(level) != nvmps_pkg::LEVEL_3))
        else $error("external execution gate wrong");
    a_hv_no_drive: assert property (hv |=> port_two_oe_n_out)
        else $error("port two driven under high voltage");
    a_entry_delay: assert property ($rose(in_session) |-> $past(high_cnt) == ENTRY_MIN && $past(rst_pin))
        else $error("session entered too early");
    a_session_exit: assert property (in_session && strobe_n |=> !in_session ##1 !session_active_out)
        else $error("session not closed");
    a_table_gate: assert property (bus_step == 2'h1 && avs_address_in == nvmps_pkg::REG_TABLE_DATA
        && level != nvmps_pkg::LEVEL_0
        |=> avs_readdata_out == 32'h0000_0000)
        else $error("table read leaked");

    c_code_write: cover property (code_wr);
    c_lock_write: cover property (fire && op == nvmps_pkg::OP_PROG_LOCK);
    c_code_verify: cover property (in_session && op == nvmps_pkg::OP_VFY_CODE && !port_two_oe_n_out);
    c_table_read: cover property (avs_read_in && !avs_waitrequest_out);
endmodule : nvmps_core

// [testbench/nvmps_prog_model.sv]
// nvmps_prog_model: programmer that drives the device pins
`timescale 1ns/1ps
module nvmps_prog_model (
    input wire logic clk_in,
    output logic [3:0] ctl_out,
    output logic [31:0] port_out
);
    // ctl: reset, fetch_n, latch_n, hv; port: zero, one, three, two
    initial {ctl_out, port_out} = {4'h6, 32'hffff_ffff};
    task automatic enter;
        {ctl_out, port_out[31:24]} <= {4'he, 8'hff};
        repeat (6) @(posedge clk_in);
        ctl_out[2] <= 1'b0;
        repeat (6) @(posedge clk_in);
    endtask : enter
    task automatic op(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d);
        port_out <= {c, a, c[6] ? d : ~port_out[7:0]};
        repeat (3) @(posedge clk_in);
        if (c[6]) begin
            ctl_out[0] <= 1'b1;
            repeat (3) @(posedge clk_in);
            ctl_out[1] <= 1'b0;
            repeat (12) @(posedge clk_in); // pulse plus sync delay
            ctl_out[1] <= 1'b1;
            ctl_out[0] <= 1'b0;
        end
        repeat (6) @(posedge clk_in);
    endtask : op
    task automatic leave;
        {ctl_out, port_out[31:24]} <= {4'h6, 8'hff};
        repeat (6) @(posedge clk_in);
    endtask : leave
endmodule : nvmps_prog_model

// [testbench/tb_top.sv]
// tb_top: self-checking bench for program, verify and lock levels
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0, rn = 1'b0, ar = 1'b0, aw = 1'b0, oe, ee, ie, ss, wq;
    logic [3:0] c, aa = 4'h0;
    logic [31:0] p, wd = 32'h0000_0000, rq, obs, q[$];
    logic [7:0] yo, d, k;
    event ev;
    int bad_count = 0, comparisons = 0;
    initial forever #5 clk = ~clk;
    nvmps_core #(.PROG_PULSE_CYCLES(8)) nvmps_core_i (.core_clk_in(clk), .rstn_in(rn), .chip_reset_pin_in(c[3]),
        .code_fetch_strobe_n_in(c[2]), .latch_program_pulse_n_in(c[1]), .external_access_hv_pin_in(c[0]),
        .port_zero_in(p[31:24]), .port_one_in(p[23:16]), .port_two_in(oe ? p[7:0] : yo), .port_three_in(p[15:8]),
        .port_two_out(yo), .port_two_oe_n_out(oe), .ext_exec_enable_out(ee), .int_exec_enable_out(ie),
        .session_active_out(ss), .avs_address_in(aa), .avs_read_in(ar), .avs_write_in(aw),
        .avs_writedata_in(wd), .avs_readdata_out(rq), .avs_waitrequest_out(wq));
    nvmps_prog_model nvmps_prog_model_i (.clk_in(clk), .ctl_out(c), .port_out(p));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    task automatic check(input logic [31:0] s, input logic [31:0] w);
        comparisons++;
        if (s !== w) bad_count++;
        if (s !== w) $display("wrong value at %0t: %h not %h", $time, s, w);
    endtask : check
    always @(ev) check(obs, q.pop_front());
    task automatic put(input logic [31:0] w, input logic [31:0] s);
        q.push_back(w);
        obs = s;
        ->ev;
        @(posedge clk);
    endtask : put
    task automatic av(input logic w, input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        {aa, ar, aw, wd} <= {a, ~w, w, v};
        do @(posedge clk); while (wq !== 1'b0);
        {ar, aw} <= 2'h0;
        if (!w) put(v, rq);
    endtask : av
    // a verify read while the device is not driving port two must fail
    task automatic op(input logic [7:0] cd, input logic [15:0] a, input logic [7:0] w);
        nvmps_prog_model_i.op(cd, a, w);
        if (!cd[6]) put(32'(w), 32'(oe ? 8'hxx : yo));
    endtask : op
    task automatic report_and_stop;
        $display("%0d checks %0d bad", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        report_and_stop;
    end
    initial begin
        d = lfsr(8'h37);
        k = lfsr(d);
        repeat (4) @(posedge clk);
        rn <= 1'b1;
        nvmps_prog_model_i.enter;
        op(8'h29, 16'h0030, 8'h11);
        op(8'h68, 16'h0005, d);
        op(8'h28, 16'h0005, d);
        op(8'h68, 16'h0005, ~d);
        op(8'h28, 16'h0005, 8'h00);
        op(8'h6c, 16'h0005, k);
        op(8'h28, 16'h0085, k);
        av(1'b1, 4'h4, 32'h0000_0085);
        av(1'b0, 4'h8, 32'h0000_00ff);
        av(1'b0, 4'hc, 32'h0000_0000);
        $display("test level zero done");
        op(8'h6b, 16'h0001, 8'h00);
        av(1'b0, 4'h0, 32'h0000_0029);
        op(8'h68, 16'h0009, 8'h00);
        op(8'h28, 16'h0009, 8'hff);
        av(1'b0, 4'h8, 32'h0000_0000);
        op(8'h6b, 16'h0002, 8'h00);
        op(8'h28, 16'h0005, 8'hff);
        op(8'h2b, 16'h0000, 8'h03);
        op(8'h6b, 16'h0003, 8'h00);
        put(32'h0000_0006, {29'h0000_0000, ss, ie, ee});
        nvmps_prog_model_i.leave;
        put(32'h0000_0000, {31'h0000_0000, ss});
        $display("test lock levels done");
        report_and_stop;
    end
endmodule : tb_top
